//--- logic/cks_regs.svh
// Register offsets, bit positions and reset values of the clock source selector.
// Assumes a 32-bit APB with byte addresses; the control register sits in the low byte.
`ifndef CKS_REGS_SVH
`define CKS_REGS_SVH

`define CKS_ADDR_W 12
`define CKS_CTRL_OFS 12'h000
`define CKS_CTRL_W 8
`define CKS_CTRL_RESET 8'h08
`define CKS_BIT_MON_IRQ_EN 7
`define CKS_BIT_MON_FLAG 6
`define CKS_BIT_MON_EN 5
`define CKS_BIT_CS 4
`define CKS_BIT_INT_ON 3
`define CKS_BIT_INT_STABLE 2
`define CKS_BIT_EXT_ON 1
`define CKS_BIT_EXT_STABLE 0
`define CKS_DET_W 5

`endif

//--- logic/cks_pkg.sv
// Types shared by the clock source selector files.
// Assumes cks_regs.svh is on the include path.
package cks_pkg;

   // -------------------------------------------------------------
   // Control register layout
   // -------------------------------------------------------------
   typedef struct packed {
      logic monitor_irq_enable;
      logic monitor_flag;
      logic monitor_enable;
      logic clock_select;
      logic internal_gen_on;
      logic internal_stable;
      logic external_gen_on;
      logic external_stable;
   } cks_ctrl_s;

   // -------------------------------------------------------------
   // Indications from the activity detectors and dividers
   // -------------------------------------------------------------
   typedef struct packed {
      logic internal_filter_stable;
      logic external_stab_done;
      logic internal_inactive;
      logic external_inactive;
      logic stop_mode;
   } cks_det_s;

endpackage : cks_pkg

//--- logic/cks_sync2.sv
// Two-flop level synchroniser of configurable width.
// Assumes the input comes from another clock domain or a pin.
`timescale 1ns/100ps

module cks_sync2 #(
   parameter int W = 1
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);

   logic [W-1:0] meta_r;

   // The first stage is read by the second stage only.
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         meta_r <= '0;
         o_q <= '0;
      end
      else
      begin
         meta_r <= i_d;
         o_q <= meta_r;
      end
   end

endmodule : cks_sync2

//--- logic/cks_glitch_switch.sv
// Glitch-free switch between two asynchronous clocks, side a being the default.
// Assumes kill inputs are levels that may arrive at any time.
`timescale 1ns/100ps

module cks_glitch_switch (
   input wire logic i_clk_a,
   input wire logic i_clk_b,
   input wire logic i_rst_n,
   input wire logic i_sel_b,
   input wire logic i_kill_a,
   input wire logic i_kill_b,
   output logic o_clk,
   output logic o_b_active
);

   logic a1_r;
   logic a2_r;
   logic b1_r;
   logic b2_r;
   wire sel_eff = i_sel_b & i_rst_n;
   wire clr_a = i_kill_a;
   wire clr_b = i_kill_b | ~i_rst_n;
   wire d_a = ~sel_eff & ~b2_r;
   wire d_b = sel_eff & ~a2_r;

   // -------------------------------------------------------------
   // Side chains on falling edges
   // -------------------------------------------------------------
   // Falling-edge flops change the enable while the clock is low, so no pulse is cut.
   // A dead clock cannot run its chain, so its side is cleared without it.
   always_ff @(negedge i_clk_a or posedge clr_a)
   begin
      if (clr_a)
      begin
         a1_r <= 1'b0;
         a2_r <= 1'b0;
      end
      else
      begin
         a1_r <= d_a;
         a2_r <= a1_r;
      end
   end

   always_ff @(negedge i_clk_b or posedge clr_b)
   begin
      if (clr_b)
      begin
         b1_r <= 1'b0;
         b2_r <= 1'b0;
      end
      else
      begin
         b1_r <= d_b;
         b2_r <= b1_r;
      end
   end

   assign o_clk = (i_clk_a & a2_r) | (i_clk_b & b2_r);
   assign o_b_active = b2_r;

   AST_SIDES_EXCLUSIVE: assert property (@(negedge i_clk_a) disable iff (!i_rst_n)
      !(a2_r && b2_r)) else $error("Both clock sides enabled at once.");

endmodule : cks_glitch_switch

//--- logic/cks_clock_selector.sv
// Clock source selector: control register, interlocks and two glitch-free switches.
// Assumes APB on i_core_clk and detector levels arriving asynchronously.
`timescale 1ns/100ps
`include "cks_regs.svh"

module cks_clock_selector
   import cks_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [`CKS_ADDR_W-1:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic i_internal_clk,
   input wire logic i_external_clk,
   input wire cks_det_s i_det,
   output logic o_osc_out_clk,
   output logic o_gen_out_clk,
   output logic o_timebase_clk,
   output logic o_internal_gen_on,
   output logic o_external_gen_on,
   output logic o_monitor_enable,
   output logic o_monitor_irq
);

   // -------------------------------------------------------------
   // Synchronised inputs
   // -------------------------------------------------------------
   cks_det_s det_s;
   logic osc_ext_s;
   logic osc_ext_raw;

   cks_sync2 #(.W(`CKS_DET_W)) u_det_sync (
      .i_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .i_d(i_det),
      .o_q(det_s)
   );

   cks_sync2 #(.W(1)) u_sel_sync (
      .i_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .i_d(osc_ext_raw),
      .o_q(osc_ext_s)
   );

   // -------------------------------------------------------------
   // APB slave
   // -------------------------------------------------------------
   // One wait state lets read data come from a flop.
   logic ack_r;
   logic [31:0] prdata_r;
   cks_ctrl_s ctrl;
   cks_ctrl_s wdat;
   wire access = i_psel & i_penable;
   wire hit = (i_paddr == `CKS_CTRL_OFS);
   wire wr_en = access & i_pwrite & ack_r & hit;

   assign wdat = cks_ctrl_s'(i_pwdata[`CKS_CTRL_W-1:0]);
   assign o_pready = ack_r;
   assign o_pslverr = ack_r & ~hit;
   assign o_prdata = prdata_r;

   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
      begin
         ack_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
      end
      else
      begin
         ack_r <= access & ~ack_r;
         if (access & ~ack_r)
         begin
            prdata_r <= hit ? {24'h00_0000, ctrl} : 32'h0000_0000;
         end
      end
   end

   // -------------------------------------------------------------
   // Control state
   // -------------------------------------------------------------
   logic irq_en_r;
   logic irq_en_nxt;
   logic flag_r;
   logic flag_nxt;
   logic mon_en_r;
   logic mon_en_nxt;
   logic cs_r;
   logic cs_nxt;
   logic int_on_r;
   logic int_on_nxt;
   logic ext_on_r;
   logic ext_on_nxt;
   logic int_stable_r;
   logic ext_stable_r;
   logic off_pend_r;
   logic off_pend_nxt;

   wire all_ok = int_on_r & ext_on_r & int_stable_r & ext_stable_r;
   wire cs_ok = int_on_r & ext_on_r & (wdat.clock_select ? ext_stable_r : int_stable_r);
   wire force_int = mon_en_r & det_s.external_inactive;
   wire force_ext = mon_en_r & det_s.internal_inactive & ~det_s.external_inactive;
   wire flag_set = mon_en_r & (det_s.internal_inactive | det_s.external_inactive);
   wire flag_clr = wr_en & ~wdat.monitor_flag;
   wire int_off_ok = cs_r & osc_ext_s;

   assign cs_nxt = force_int ? 1'b0 :
                   force_ext ? 1'b1 :
                   (wr_en & cs_ok) ? wdat.clock_select : cs_r;
   assign mon_en_nxt = !wr_en ? mon_en_r :
                       wdat.monitor_enable & (mon_en_r | all_ok);
   assign irq_en_nxt = !wr_en ? irq_en_r :
                       wdat.monitor_irq_enable & mon_en_r;
   assign flag_nxt = flag_set | (flag_r & ~flag_clr);
   assign ext_on_nxt = wr_en ? wdat.external_gen_on : ext_on_r;

   // A request to stop the internal source is parked until the oscillator switch really runs on
   // the external clock, so software cannot stop the internal clock while it drives o_osc_out_clk.
   assign int_on_nxt = (wr_en & wdat.internal_gen_on) ? 1'b1 :
                       ((wr_en | off_pend_r) & int_off_ok) ? 1'b0 : int_on_r;
   assign off_pend_nxt = (wr_en & wdat.internal_gen_on) ? 1'b0 :
                         (wr_en & ~int_off_ok) ? 1'b1 :
                         int_off_ok ? 1'b0 : off_pend_r;

   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
      begin
         {irq_en_r, flag_r, mon_en_r, cs_r, int_on_r} <= 5'(`CKS_CTRL_RESET >> `CKS_BIT_INT_ON);
         ext_on_r <= 1'b0;
         off_pend_r <= 1'b0;
         int_stable_r <= 1'b0;
         ext_stable_r <= 1'b0;
      end
      else
      begin
         irq_en_r <= irq_en_nxt;
         flag_r <= flag_nxt;
         mon_en_r <= mon_en_nxt;
         cs_r <= cs_nxt;
         int_on_r <= int_on_nxt;
         ext_on_r <= ext_on_nxt;
         off_pend_r <= off_pend_nxt;
         // Stable flags follow the detectors, gated by the generator-on bits; written stable values never reach them.
         int_stable_r <= det_s.internal_filter_stable & int_on_r & ~det_s.stop_mode
                         & ~det_s.internal_inactive;
         ext_stable_r <= det_s.external_stab_done & ext_on_r & ~det_s.stop_mode
                         & ~det_s.external_inactive;
      end
   end

   assign ctrl = '{monitor_irq_enable: irq_en_r, monitor_flag: flag_r,
                   monitor_enable: mon_en_r, clock_select: cs_r,
                   internal_gen_on: int_on_r, internal_stable: int_stable_r,
                   external_gen_on: ext_on_r, external_stable: ext_stable_r};

   assign o_internal_gen_on = int_on_r;
   assign o_external_gen_on = ext_on_r;
   assign o_monitor_enable = mon_en_r;
   assign o_monitor_irq = flag_r & irq_en_r;

   // -------------------------------------------------------------
   // Clock switches and divider
   // -------------------------------------------------------------
   // The kills clear switch flops asynchronously, so they come straight from flops.
   // A gate of several flops could pulse briefly while its inputs change together.
   logic kill_int_r;
   logic kill_ext_r;

   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
      begin
         kill_int_r <= 1'b0;
         kill_ext_r <= 1'b0;
      end
      else
      begin
         kill_int_r <= force_int;
         kill_ext_r <= force_ext;
      end
   end

   wire tb_sel = (ext_on_r & ~force_int) | force_ext;

   cks_glitch_switch u_osc_switch (
      .i_clk_a(i_internal_clk),
      .i_clk_b(i_external_clk),
      .i_rst_n(i_rst_n),
      .i_sel_b(cs_r),
      .i_kill_a(kill_ext_r),
      .i_kill_b(kill_int_r),
      .o_clk(o_osc_out_clk),
      .o_b_active(osc_ext_raw)
   );

   cks_glitch_switch u_tb_switch (
      .i_clk_a(i_internal_clk),
      .i_clk_b(i_external_clk),
      .i_rst_n(i_rst_n),
      .i_sel_b(tb_sel),
      .i_kill_a(kill_ext_r),
      .i_kill_b(kill_int_r),
      .o_clk(o_timebase_clk),
      .o_b_active()
   );

   // The divider must start from a known phase even if the selected clock is slow.
   logic gen_r;
   always_ff @(posedge o_osc_out_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         gen_r <= 1'b0;
      end
      else
      begin
         gen_r <= ~gen_r;
      end
   end
   assign o_gen_out_clk = gen_r;

   // -------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);

   sequence s_sel_write_ok;
      wr_en && cs_ok;
   endsequence

   sequence s_sel_changed;
      $changed(cs_r) && !$past(force_int) && !$past(force_ext);
   endsequence

   AST_CS_GUARD: assert property (s_sel_changed |-> $past(wr_en && cs_ok))
      else $error("Select changed without a permitted write.");
   AST_CS_TAKE: assert property (s_sel_write_ok ##0 (!force_int && !force_ext)
      |=> cs_r == $past(wdat.clock_select))
      else $error("Permitted select write was lost.");
   AST_MON_GUARD: assert property ($rose(mon_en_r) |-> $past(all_ok))
      else $error("Monitor enabled before both sources were stable.");
   AST_IRQ_GUARD: assert property ($rose(irq_en_r) |-> $past(mon_en_r))
      else $error("Monitor interrupt enabled without the monitor.");
   AST_FLAG_CLEAR: assert property (flag_clr && !flag_set |=> !flag_r)
      else $error("Writing zero did not clear the monitor flag.");
   AST_FLAG_KEEP: assert property (flag_r && !flag_clr |=> flag_r)
      else $error("Monitor flag lost without a zero write.");
   AST_EXT_STABLE: assert property (!ext_on_r || det_s.external_inactive |=> !ext_stable_r)
      else $error("External stable flag stayed set.");
   AST_FORCE_SEL: assert property (force_int |-> !tb_sel ##1 !cs_r)
      else $error("Forced reselection did not show in the select bit.");
   AST_INT_HOLD: assert property (int_on_r && !int_off_ok |=> int_on_r)
      else $error("Internal source stopped while still in use.");
   AST_RD_FLAG: assert property (access && !ack_r && hit && !i_pwrite
      |=> o_prdata[`CKS_BIT_MON_FLAG] == $past(flag_r))
      else $error("Read data bit six does not show the monitor flag.");
   AST_RESET_INT: assert property (@(posedge i_core_clk) disable iff (1'b0)
      !i_rst_n |=> !cs_r && int_on_r)
      else $error("Reset did not select the internal clock.");

   sequence s_ext_forced;
      force_ext ##1 cs_r;
   endsequence

   AST_FORCE_EXT: assert property (force_ext |-> tb_sel ##0 s_ext_forced)
      else $error("Forced external selection did not show in the select bit.");
   AST_FLAG_SET: assert property (flag_set |=> flag_r)
      else $error("Monitor flag not set while a source was inactive.");
   AST_STOP_STABLE: assert property (det_s.stop_mode |=> !int_stable_r && !ext_stable_r)
      else $error("Stable flag stayed set in stop.");
   AST_RO_STABLE: assert property (wr_en && !det_s.internal_filter_stable |=> !int_stable_r)
      else $error("A write set the internal stable flag.");
   AST_WR_MISS: assert property (access && ack_r && !hit |=> $stable({irq_en_r, mon_en_r, ext_on_r}))
      else $error("Unmapped access changed the control register.");

endmodule : cks_clock_selector

//--- verification/cks_clock_selector_tb.sv
// Self-checking bench for the clock source selector: register model, APB master, clock checks.
// Assumes cks_pkg is compiled first and cks_regs.svh is on the include path.
`timescale 1ns/100ps
`include "cks_regs.svh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin miscompares++; \
   $display("unexpected at %0t: got %0h expected %0h", $time, a, b); end end

module cks_clock_selector_tb
   import cks_pkg::*;
;
   logic i_core_clk = 1'h0;
   logic i_internal_clk = 1'h0;
   logic i_external_clk = 1'h0;
   logic run_i = 1'h1;
   logic run_e = 1'h1;
   logic i_rst_n, i_psel, i_penable, i_pwrite;
   logic [11:0] i_paddr;
   logic [31:0] i_pwdata, o_prdata;
   logic o_pready, o_pslverr, o_osc_out_clk, o_gen_out_clk, o_timebase_clk;
   logic o_internal_gen_on, o_external_gen_on, o_monitor_enable, o_monitor_irq;
   cks_det_s i_det;
   cks_ctrl_s exp;
   int miscompares = 0;
   int compares = 0;
   time t_o = 0;
   time t_t = 0;

   // -------------------------------------------------------------
   // Clocks and device
   // -------------------------------------------------------------
   // Source clocks stop low when their run flag drops, as a dead source would.
   always #50 i_core_clk = ~i_core_clk;
   always #17 i_internal_clk = run_i & ~i_internal_clk;
   always #23 i_external_clk = run_e & ~i_external_clk;

   cks_clock_selector DUT (
      .i_core_clk, .i_rst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
      .o_prdata, .o_pready, .o_pslverr, .i_internal_clk, .i_external_clk, .i_det,
      .o_osc_out_clk, .o_gen_out_clk, .o_timebase_clk, .o_internal_gen_on,
      .o_external_gen_on, .o_monitor_enable, .o_monitor_irq
   );

   // No pulse may be shorter than the faster source's half period.
   always @(o_osc_out_clk)
   begin
      if (i_rst_n === 1'h1 && $time - t_o < 16) `CHK($time - t_o, 64'h11)
      t_o = $time;
   end

   always @(o_timebase_clk)
   begin
      if (i_rst_n === 1'h1 && $time - t_t < 16) `CHK($time - t_t, 64'h11)
      t_t = $time;
   end

   // -------------------------------------------------------------
   // Model and bus tasks
   // -------------------------------------------------------------
   function automatic cks_ctrl_s settle(cks_ctrl_s c);
      if (c.monitor_enable && i_det.external_inactive) c.clock_select = 1'h0;
      else if (c.monitor_enable && i_det.internal_inactive) c.clock_select = 1'h1;
      c.monitor_flag |= c.monitor_enable & (i_det.internal_inactive | i_det.external_inactive);
      c.internal_stable = i_det.internal_filter_stable & c.internal_gen_on &
         ~i_det.stop_mode & ~i_det.internal_inactive;
      c.external_stable = i_det.external_stab_done & c.external_gen_on &
         ~i_det.stop_mode & ~i_det.external_inactive;
      return c;
   endfunction : settle

   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
      output logic [31:0] rd, output logic err);
      int n = 0;
      @(posedge i_core_clk);
      i_psel <= 1'h1;
      i_penable <= 1'h0;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= wd;
      @(posedge i_core_clk);
      i_penable <= 1'h1;
      // Response and read data are taken at the very edge where pready is sampled high.
      do
      begin
         @(posedge i_core_clk);
         n++;
      end
      while (o_pready !== 1'h1 && n < 20);
      if (n >= 20)
      begin
         miscompares++;
         summarize();
      end
      else
      begin
         rd = o_prdata;
         err = o_pslverr;
         i_psel <= 1'h0;
         i_penable <= 1'h0;
      end
   endtask : xfer

   task automatic idle(input int n);
      repeat (n) @(posedge i_core_clk);
   endtask : idle

   task automatic chk_reg();
      logic [31:0] rd;
      logic err;
      xfer(1'h0, `CKS_CTRL_OFS, $urandom, rd, err);
      `CHK({err, rd}, {1'h0, 24'h000000, exp})
      `CHK({o_monitor_irq, o_monitor_enable, o_external_gen_on, o_internal_gen_on},
         {exp.monitor_flag & exp.monitor_irq_enable, exp.monitor_enable,
         exp.external_gen_on, exp.internal_gen_on})
   endtask : chk_reg

   task automatic look();
      idle(40);
      exp = settle(exp);
      chk_reg();
   endtask : look

   task automatic wr(input logic [7:0] d);
      cks_ctrl_s n;
      logic [31:0] rd;
      logic err;
      n = exp;
      if (exp.internal_gen_on && exp.external_gen_on &&
         (d[4] ? exp.external_stable : exp.internal_stable)) n.clock_select = d[4];
      n.internal_gen_on = d[3] | ~n.clock_select;
      n.external_gen_on = d[1];
      n.monitor_enable = d[5] & (exp.monitor_enable | (&exp[3:0]));
      n.monitor_irq_enable = d[7] & exp.monitor_enable;
      n.monitor_flag = exp.monitor_flag & d[6];
      xfer(1'h1, `CKS_CTRL_OFS, {24'($urandom), d}, rd, err);
      `CHK(err, 1'h0)
      @(negedge i_core_clk);
      if (n.clock_select && !exp.clock_select) `CHK(o_internal_gen_on, 1'h1)
      exp = n;
      look();
   endtask : wr

   task automatic follow(input logic oe, input logic te);
      repeat (4)
      begin
         if (oe) @(i_external_clk); else @(i_internal_clk);
         #1;
         `CHK(o_osc_out_clk, oe ? i_external_clk : i_internal_clk)
      end
      repeat (4)
      begin
         if (te) @(i_external_clk); else @(i_internal_clk);
         #1;
         `CHK(o_timebase_clk, te ? i_external_clk : i_internal_clk)
      end
   endtask : follow

   task automatic genchk();
      logic g;
      repeat (3)
      begin
         @(posedge o_osc_out_clk);
         #1;
         g = o_gen_out_clk;
         @(posedge o_osc_out_clk);
         #1;
         `CHK(o_gen_out_clk, ~g)
      end
   endtask : genchk

   task automatic summarize();
      if (miscompares == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : summarize

   // -------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------
   initial
   begin
      #2ms;
      miscompares++;
      summarize();
   end

   initial
   begin
      logic [31:0] rd;
      logic err;
      logic [11:0] a;
      i_rst_n = 1'h0;
      i_psel = 1'h0;
      i_penable = 1'h0;
      i_pwrite = 1'h0;
      i_paddr = 12'h000;
      i_pwdata = 32'h00000000;
      i_det = 5'h10;
      void'($urandom(60563));
      idle(6);
      i_rst_n <= 1'h1;
      exp = `CKS_CTRL_RESET;
      look();
      follow(1'h0, 1'h0);
      genchk();
      repeat (4)
      begin
         a = 12'($urandom_range(4095, 1));
         xfer(1'h1, a, $urandom, rd, err);
         `CHK(err, 1'h1)
         xfer(1'h0, a, $urandom, rd, err);
         `CHK({err, rd}, {1'h1, 32'h00000000})
      end
      chk_reg();
      wr(8'h0D);
      wr(8'h1A);
      follow(1'h0, 1'h1);
      wr(8'hAA);
      wr(8'h1A);
      i_det.external_stab_done <= 1'h1;
      wr(8'h0A);
      wr(8'h12);
      follow(1'h1, 1'h1);
      genchk();
      wr(8'h0A);
      wr(8'h0A);
      follow(1'h0, 1'h1);
      wr(8'hAF);
      wr(8'hAF);
      wr(8'hBF);
      run_e <= 1'h0;
      i_det.external_inactive <= 1'h1;
      look();
      follow(1'h0, 1'h0);
      wr(8'hEE);
      wr(8'hAE);
      i_det.external_inactive <= 1'h0;
      run_e <= 1'h1;
      idle(10);
      wr(8'hAE);
      run_i <= 1'h0;
      i_det.internal_inactive <= 1'h1;
      look();
      follow(1'h1, 1'h1);
      i_det.internal_inactive <= 1'h0;
      run_i <= 1'h1;
      idle(10);
      wr(8'h1A);
      i_det.stop_mode <= 1'h1;
      wr(8'h1A);
      summarize();
   end

endmodule : cks_clock_selector_tb
